// ==== presc_pkg.sv ====
package presc_pkg;

    // Port count and bus geometry
    localparam int          NUM_PORTS   = 4;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          PORT_STRIDE = 16;

    // Per-port register offsets, relative to the port base
    localparam logic [7:0]  OFS_CTL     = 8'h00;
    localparam logic [7:0]  OFS_SIL     = 8'h04;
    localparam logic [7:0]  OFS_MCAST   = 8'h08;
    localparam logic [7:0]  OFS_ERRDET  = 8'h0c;

    // Block-wide interrupt registers
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h40;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h44;

    // Port control field positions
    localparam int          CTL_RETRY_EN_BIT  = 17;
    localparam int          CTL_RETRY_ERR_BIT = 16;
    localparam int          CTL_THR_LSB       = 8;
    localparam int          THR_W             = 8;
    localparam int          CTL_IRQ_EN_BIT    = 7;
    localparam int          CTL_IRQ_ERR_BIT   = 6;
    localparam logic [7:0]  CTL_THR_RESET     = 8'h00;

    // Silence duration field
    localparam int          SIL_LSB   = 28;
    localparam int          SIL_W     = 4;
    localparam logic [3:0]  SIL_RESET = 4'hb;

    // Error detect mirror bit
    localparam int          ERRDET_RETRY_BIT = 20;

    // Interrupt status layout: retry reports, then silence ends
    localparam int          IRQ_RETRY_LSB  = 0;
    localparam int          IRQ_SILDONE_LSB = NUM_PORTS;
    localparam int          IRQ_W          = 2 * NUM_PORTS;

    // Timing, in picoseconds, and the cycle counts derived from it
    localparam int          CLK_PERIOD_PS     = 10000;
    localparam int          SILENCE_UNIT_PS   = 13100000;
    localparam int          SILENCE_DEBUG_PS  = 64000;
    localparam int          SILENCE_UNIT_CYC  = SILENCE_UNIT_PS / CLK_PERIOD_PS;
    localparam int          SILENCE_DEBUG_CYC =
        (SILENCE_DEBUG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        SIL_IDLE  = 3'b001,
        SIL_DEBUG = 3'b010,
        SIL_RUN   = 3'b100
    } presc_sil_state_e;

endpackage : presc_pkg

// ==== presc_retry.sv ====
module presc_retry #(
    parameter int CNT_W = presc_pkg::THR_W
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Link events
    input  wire logic             retry_rsp,
    input  wire logic             pkt_accepted,
    // Programmed threshold and result
    input  wire logic [CNT_W-1:0] threshold,
    output logic                  limit_hit
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] cnt_inc;

    always_comb begin
        // Saturate so a stuck partner cannot wrap back under the limit
        cnt_inc   = (cnt == '1) ? cnt : CNT_W'(cnt + 1'b1);
        next_cnt  = cnt;
        limit_hit = 1'b0;
        if (pkt_accepted) begin
            next_cnt = '0;
        end else if (retry_rsp) begin
            next_cnt  = cnt_inc;
            limit_hit = (threshold != '0) && (cnt_inc == threshold) && (cnt_inc != cnt);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    a_thr_zero_off: assert property (@(posedge pclk) disable iff (!presetn)
        threshold == '0 |-> !limit_hit)
        else $error("retry limit flagged with zero threshold");

    a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
        pkt_accepted |=> cnt == '0)
        else $error("retry count not cleared on acceptance");

    a_hit_count: assert property (@(posedge pclk) disable iff (!presetn)
        limit_hit |=> cnt == $past(threshold))
        else $error("retry limit flagged at wrong count");

endmodule : presc_retry

// ==== presc_silence.sv ====
module presc_silence #(
    parameter int UNIT_CYCLES  = presc_pkg::SILENCE_UNIT_CYC,
    parameter int DEBUG_CYCLES = presc_pkg::SILENCE_DEBUG_CYC
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // Control
    input  wire logic                          start,
    input  wire logic [presc_pkg::SIL_W-1:0]   code,
    // Status
    output logic                               silent,
    output logic                               done
);

    localparam int DIV_W = $clog2((UNIT_CYCLES > DEBUG_CYCLES ? UNIT_CYCLES : DEBUG_CYCLES) + 1);

    presc_pkg::presc_sil_state_e        state;
    presc_pkg::presc_sil_state_e        next_state;
    logic [DIV_W-1:0]                   div;
    logic [DIV_W-1:0]                   next_div;
    logic [presc_pkg::SIL_W-1:0]        units;
    logic [presc_pkg::SIL_W-1:0]        next_units;
    logic [presc_pkg::SIL_W-1:0]        code_l;
    logic [presc_pkg::SIL_W-1:0]        next_code_l;
    logic                               next_silent;
    logic                               next_done;
    logic                               tick;

    always_comb begin
        next_state  = state;
        next_div    = div;
        next_units  = units;
        next_code_l = code_l;
        next_silent = silent;
        next_done   = 1'b0;
        tick        = (div == DIV_W'(UNIT_CYCLES - 1));
        unique case (state)
            presc_pkg::SIL_IDLE: begin
                // Code is latched so a rewrite cannot stretch a running period
                if (start) begin
                    next_code_l = code;
                    next_div    = '0;
                    next_units  = '0;
                    next_silent = 1'b1;
                    next_state  = (code == '0) ? presc_pkg::SIL_DEBUG : presc_pkg::SIL_RUN;
                end
            end
            presc_pkg::SIL_DEBUG: begin
                next_div = DIV_W'(div + 1'b1);
                if (div == DIV_W'(DEBUG_CYCLES - 1)) begin
                    next_state  = presc_pkg::SIL_IDLE;
                    next_silent = 1'b0;
                    next_done   = 1'b1;
                end
            end
            presc_pkg::SIL_RUN: begin
                next_div = tick ? '0 : DIV_W'(div + 1'b1);
                if (tick) begin
                    next_units = presc_pkg::SIL_W'(units + 1'b1);
                    if (units == presc_pkg::SIL_W'(code_l - 1'b1)) begin
                        next_state  = presc_pkg::SIL_IDLE;
                        next_silent = 1'b0;
                        next_done   = 1'b1;
                    end
                end
            end
            default: begin
                next_state  = presc_pkg::SIL_IDLE;
                next_silent = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= presc_pkg::SIL_IDLE;
            div    <= '0;
            units  <= '0;
            code_l <= '0;
            silent <= 1'b0;
            done   <= 1'b0;
        end else begin
            state  <= next_state;
            div    <= next_div;
            units  <= next_units;
            code_l <= next_code_l;
            silent <= next_silent;
            done   <= next_done;
        end
    end

    // Helper: length of the current silent period
    logic [31:0] len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len <= '0;
        end else begin
            len <= silent ? len + 32'h1 : '0;
        end
    end

    a_silence_len: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(silent) |-> len == ((code_l == '0) ? 32'(DEBUG_CYCLES)
                                                 : 32'(code_l) * 32'(UNIT_CYCLES)))
        else $error("silent period has wrong length");

endmodule : presc_silence

// ==== presc_top.sv ====
// Chosen here: the register addresses and the APB slave port.
module presc_top #(
    parameter int SILENCE_UNIT_CYCLES = presc_pkg::SILENCE_UNIT_CYC,
    parameter int DEBUG_CYCLES        = presc_pkg::SILENCE_DEBUG_CYC
) (
    // Clock and reset
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    // APB slave
    input  wire logic                              psel,
    input  wire logic                              penable,
    input  wire logic                              pwrite,
    input  wire logic [presc_pkg::ADDR_W-1:0]      paddr,
    input  wire logic [presc_pkg::DATA_W-1:0]      pwdata,
    output logic      [presc_pkg::DATA_W-1:0]      prdata,
    output logic                                   pready,
    output logic                                   pslverr,
    // Link events, one bit per port
    input  wire logic [presc_pkg::NUM_PORTS-1:0]   retry_rsp,
    input  wire logic [presc_pkg::NUM_PORTS-1:0]   pkt_accepted,
    input  wire logic [presc_pkg::NUM_PORTS-1:0]   silence_start,
    // Per-port outputs
    output logic      [presc_pkg::NUM_PORTS-1:0]   port_write_req,
    output logic      [presc_pkg::NUM_PORTS-1:0]   port_irq,
    output logic      [presc_pkg::NUM_PORTS-1:0]   mcast_symbol_req,
    output logic      [presc_pkg::NUM_PORTS-1:0]   port_silent,
    // Block interrupt
    output logic                                   irq
);

    localparam int NP = presc_pkg::NUM_PORTS;
    localparam int DW = presc_pkg::DATA_W;
    localparam int IW = presc_pkg::IRQ_W;

    // Port control fields
    logic [NP-1:0]                     retry_en;
    logic [NP-1:0]                     retry_err;
    logic [NP-1:0]                     irq_en;
    logic [NP-1:0]                     irq_err;
    logic [NP-1:0]                     errdet_retry;
    logic [presc_pkg::THR_W-1:0]       retry_limit_threshold [NP];
    logic [presc_pkg::SIL_W-1:0]       sil_code [NP];
    logic [NP-1:0]                     next_retry_en;
    logic [NP-1:0]                     next_retry_err;
    logic [NP-1:0]                     next_irq_en;
    logic [NP-1:0]                     next_irq_err;
    logic [NP-1:0]                     next_errdet_retry;
    logic [presc_pkg::THR_W-1:0]       next_thr [NP];
    logic [presc_pkg::SIL_W-1:0]       next_sil_code [NP];
    logic [NP-1:0]                     next_port_write_req;
    logic [NP-1:0]                     next_port_irq;
    logic [NP-1:0]                     next_mcast;

    // Block interrupt state
    logic [IW-1:0]                     irq_stat;
    logic [IW-1:0]                     irq_mask;
    logic [IW-1:0]                     next_irq_stat;
    logic [IW-1:0]                     next_irq_mask;
    logic                              next_irq;

    // Bus state
    logic [DW-1:0]                     next_prdata;
    logic                              next_pready;
    logic                              next_pslverr;

    // Decode and events
    logic                              setup;
    logic                              wr_en;
    logic [NP-1:0]                     hit_ctl;
    logic [NP-1:0]                     hit_sil;
    logic [NP-1:0]                     hit_mc;
    logic [NP-1:0]                     hit_err;
    logic                              hit_stat;
    logic                              hit_mask;
    logic                              mapped;
    logic [DW-1:0]                     rd_data;
    logic [NP-1:0]                     limit_hit;
    logic [NP-1:0]                     sil_done;

    // Per-port detectors and timers
    for (genvar g = 0; g < NP; g++) begin : g_port
        presc_retry #(
            .CNT_W (presc_pkg::THR_W)
        ) u_retry (
            .pclk         (pclk),
            .presetn      (presetn),
            .retry_rsp    (retry_rsp[g]),
            .pkt_accepted (pkt_accepted[g]),
            .threshold    (retry_limit_threshold[g]),
            .limit_hit    (limit_hit[g])
        );
        presc_silence #(
            .UNIT_CYCLES  (SILENCE_UNIT_CYCLES),
            .DEBUG_CYCLES (DEBUG_CYCLES)
        ) u_silence (
            .pclk    (pclk),
            .presetn (presetn),
            .start   (silence_start[g]),
            .code    (sil_code[g]),
            .silent  (port_silent[g]),
            .done    (sil_done[g])
        );
    end

    // Address decode and read mux
    always_comb begin
        setup    = psel && !penable;
        wr_en    = psel && penable && pready && pwrite;
        hit_stat = (paddr == presc_pkg::OFS_IRQ_STAT);
        hit_mask = (paddr == presc_pkg::OFS_IRQ_MASK);
        rd_data  = '0;
        if (hit_stat) begin
            rd_data[IW-1:0] = irq_stat;
        end
        if (hit_mask) begin
            rd_data[IW-1:0] = irq_mask;
        end
        for (int p = 0; p < NP; p++) begin
            hit_ctl[p] = (paddr == 8'(p * presc_pkg::PORT_STRIDE) + presc_pkg::OFS_CTL);
            hit_sil[p] = (paddr == 8'(p * presc_pkg::PORT_STRIDE) + presc_pkg::OFS_SIL);
            hit_mc[p]  = (paddr == 8'(p * presc_pkg::PORT_STRIDE) + presc_pkg::OFS_MCAST);
            hit_err[p] = (paddr == 8'(p * presc_pkg::PORT_STRIDE) + presc_pkg::OFS_ERRDET);
            if (hit_ctl[p]) begin
                rd_data[presc_pkg::CTL_RETRY_EN_BIT]  = retry_en[p];
                rd_data[presc_pkg::CTL_RETRY_ERR_BIT] = retry_err[p];
                rd_data[presc_pkg::CTL_THR_LSB +: presc_pkg::THR_W] = retry_limit_threshold[p];
                rd_data[presc_pkg::CTL_IRQ_EN_BIT]    = irq_en[p];
                rd_data[presc_pkg::CTL_IRQ_ERR_BIT]   = irq_err[p];
            end
            if (hit_sil[p]) begin
                rd_data[presc_pkg::SIL_LSB +: presc_pkg::SIL_W] = sil_code[p];
            end
            if (hit_err[p]) begin
                rd_data[presc_pkg::ERRDET_RETRY_BIT] = errdet_retry[p];
            end
        end
        // Multicast request register reads as zero
        mapped = hit_stat || hit_mask || (|hit_ctl) || (|hit_sil) || (|hit_mc) || (|hit_err);
    end

    // APB answer: prepared in setup, so access completes without wait states
    always_comb begin
        next_pready  = setup;
        next_pslverr = setup && !mapped;
        next_prdata  = (setup && !pwrite) ? rd_data : '0;
    end

    // Port register next values
    always_comb begin
        next_retry_en       = retry_en;
        next_retry_err      = retry_err;
        next_irq_en         = irq_en;
        next_irq_err        = irq_err;
        next_errdet_retry   = errdet_retry;
        next_thr            = retry_limit_threshold;
        next_sil_code       = sil_code;
        next_port_write_req = '0;
        next_mcast          = '0;
        for (int p = 0; p < NP; p++) begin
            if (wr_en && hit_ctl[p]) begin
                next_retry_en[p] = pwdata[presc_pkg::CTL_RETRY_EN_BIT];
                next_thr[p]      = pwdata[presc_pkg::CTL_THR_LSB +: presc_pkg::THR_W];
                next_irq_en[p]   = pwdata[presc_pkg::CTL_IRQ_EN_BIT];
                if (pwdata[presc_pkg::CTL_RETRY_ERR_BIT]) begin
                    next_retry_err[p] = 1'b0;
                end
                if (pwdata[presc_pkg::CTL_IRQ_ERR_BIT]) begin
                    next_irq_err[p] = 1'b0;
                end
            end
            if (wr_en && hit_err[p]) begin
                next_errdet_retry[p] = pwdata[presc_pkg::ERRDET_RETRY_BIT];
                if (pwdata == '0) begin
                    next_retry_err[p] = 1'b0;
                end
            end
            if (wr_en && hit_sil[p]) begin
                next_sil_code[p] = pwdata[presc_pkg::SIL_LSB +: presc_pkg::SIL_W];
            end
            // Data is ignored; the write itself is the request
            next_mcast[p] = wr_en && hit_mc[p];
            // Set after clear so a same-cycle event is not lost
            if (limit_hit[p]) begin
                next_retry_err[p]    = 1'b1;
                next_errdet_retry[p] = 1'b1;
                if (retry_en[p]) begin
                    next_port_write_req[p] = 1'b1;
                    next_irq_err[p]        = 1'b1;
                end
            end
        end
        next_port_irq = next_irq_err & next_irq_en;
    end

    // Block status, mask and interrupt line
    always_comb begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (wr_en && hit_stat) begin
            next_irq_stat = irq_stat & ~pwdata[IW-1:0];
        end
        if (wr_en && hit_mask) begin
            next_irq_mask = pwdata[IW-1:0];
        end
        next_irq_stat[presc_pkg::IRQ_RETRY_LSB +: NP] =
            next_irq_stat[presc_pkg::IRQ_RETRY_LSB +: NP] | (limit_hit & retry_en);
        next_irq_stat[presc_pkg::IRQ_SILDONE_LSB +: NP] =
            next_irq_stat[presc_pkg::IRQ_SILDONE_LSB +: NP] | sil_done;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retry_en              <= '0;
            retry_err             <= '0;
            irq_en                <= '0;
            irq_err               <= '0;
            errdet_retry          <= '0;
            retry_limit_threshold <= '{default: presc_pkg::CTL_THR_RESET};
            sil_code              <= '{default: presc_pkg::SIL_RESET};
            port_write_req        <= '0;
            port_irq              <= '0;
            mcast_symbol_req      <= '0;
            irq_stat              <= '0;
            irq_mask              <= '0;
            irq                   <= 1'b0;
            prdata                <= '0;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
        end else begin
            retry_en              <= next_retry_en;
            retry_err             <= next_retry_err;
            irq_en                <= next_irq_en;
            irq_err               <= next_irq_err;
            errdet_retry          <= next_errdet_retry;
            retry_limit_threshold <= next_thr;
            sil_code              <= next_sil_code;
            port_write_req        <= next_port_write_req;
            port_irq              <= next_port_irq;
            mcast_symbol_req      <= next_mcast;
            irq_stat              <= next_irq_stat;
            irq_mask              <= next_irq_mask;
            irq                   <= next_irq;
            prdata                <= next_prdata;
            pready                <= next_pready;
            pslverr               <= next_pslverr;
        end
    end

    for (genvar g = 0; g < NP; g++) begin : g_chk
        a_retry_set: assert property (@(posedge pclk) disable iff (!presetn)
            limit_hit[g] |=> retry_err[g] && errdet_retry[g])
            else $error("retry limit not flagged");

        a_retry_sticky: assert property (@(posedge pclk) disable iff (!presetn)
            retry_err[g] && !(wr_en && hit_ctl[g] && pwdata[presc_pkg::CTL_RETRY_ERR_BIT])
                && !(wr_en && hit_err[g] && pwdata == '0) |=> retry_err[g])
            else $error("retry flag dropped without clear");

        a_errdet_zero: assert property (@(posedge pclk) disable iff (!presetn)
            wr_en && hit_err[g] && pwdata == '0 && !limit_hit[g] |=> !retry_err[g])
            else $error("zero error detect write did not clear flag");

        a_report_on: assert property (@(posedge pclk) disable iff (!presetn)
            limit_hit[g] && retry_en[g] |=> port_write_req[g] && irq_err[g] ##1 !port_write_req[g])
            else $error("enabled retry error not reported");

        a_report_off: assert property (@(posedge pclk) disable iff (!presetn)
            limit_hit[g] && !retry_en[g] && !irq_err[g] |=> !port_write_req[g] && !irq_err[g])
            else $error("disabled retry error reported");

        a_port_irq: assert property (@(posedge pclk) disable iff (!presetn)
            port_irq[g] == (irq_err[g] && irq_en[g]))
            else $error("port interrupt does not follow status and enable");

        a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
            irq_err[g] && !(wr_en && hit_ctl[g] && pwdata[presc_pkg::CTL_IRQ_ERR_BIT]) |=> irq_err[g])
            else $error("interrupt status dropped without clear");

        a_mcast_pulse: assert property (@(posedge pclk) disable iff (!presetn)
            wr_en && hit_mc[g] |=> mcast_symbol_req[g] ##1 !mcast_symbol_req[g])
            else $error("multicast request not a single pulse");
    end

    a_mcast_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        setup && !pwrite && (|hit_mc) |=> pready && prdata == '0 && !pslverr)
        else $error("multicast request register read not zero");

    a_irq_line: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(irq_stat & irq_mask))
        else $error("interrupt line disagrees with status and mask");

endmodule : presc_top

// ==== presc_link_partner.sv ====
module presc_link_partner (
    // Clock
    input  wire logic        pclk,
    // Link events towards the block
    output logic       [3:0] retry_rsp,
    output logic       [3:0] pkt_accepted
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        retry_rsp = '0;
        pkt_accepted = '0;
    end
    // Idle cycle between answers, as a slow partner would
    task automatic retries(logic [3:0] m, int n);
        repeat (n) begin
            retry_rsp <= m;
            @(posedge pclk);
            retry_rsp <= '0;
            @(posedge pclk);
        end
    endtask : retries
    // Outstanding packet finally taken, one pulse per marked port
    task automatic accept(logic [3:0] m);
        pkt_accepted <= m;
        @(posedge pclk);
        pkt_accepted <= '0;
        @(posedge pclk);
    endtask : accept
endmodule : presc_link_partner

// ==== port_retry_error_silence_ctl_tb.sv ====
module port_retry_error_silence_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, e;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [3:0]  rsp, acc, sil = '0, pwr, pirq, mc, silent;
    int          fails = 0, n_compared = 0, n;
    logic [3:0]  pwr_seen = '0, mc_seen = '0;
    always #5 pclk = ~pclk;
    // One-cycle pulses are caught at the edge, so no check can miss them
    always @(posedge pclk) begin
        pwr_seen <= presetn ? (pwr_seen | pwr) : 4'h0;
        mc_seen  <= presetn ? (mc_seen | mc) : 4'h0;
    end
    presc_top #(.SILENCE_UNIT_CYCLES(5)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .retry_rsp(rsp), .pkt_accepted(acc), .silence_start(sil), .port_write_req(pwr),
        .port_irq(pirq), .mcast_symbol_req(mc), .port_silent(silent), .irq(irq));
    presc_link_partner u_link (.pclk(pclk), .retry_rsp(rsp), .pkt_accepted(acc));
    task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Answer taken at the rising edge where pready is seen high
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        // Idle edge keeps the next call from reassigning in this time step
        @(posedge pclk);
    endtask : apb
    task automatic rd(string s, logic [7:0] a, logic [31:0] x);
        apb(0, a, 0);
        chk(s, r, x);
    endtask : rd
    task automatic t_reset();
        rd("ctl0", 8'h00, 32'h0);
        rd("sil0", 8'h04, 32'hb0000000);
        apb(0, 8'h80, 0);
        chk("slverr", e, 1);
    endtask : t_reset
    task automatic t_retry();
        apb(1, 8'h10, 32'h00020280);
        apb(1, 8'h20, 32'h00000100);
        apb(1, 8'h30, 32'h0);
        u_link.retries(4'b1110, 2);
        rd("ctl1", 8'h10, 32'h000302c0);
        chk("port write", pwr_seen, 4'b0010);
        chk("port_irq", pirq, 4'b0010);
        rd("errdet1", 8'h1c, 32'h00100000);
        rd("ctl2", 8'h20, 32'h00010100);
        rd("ctl3", 8'h30, 32'h0);
        apb(1, 8'h20, 32'h00010100);
        rd("ctl2 w1c", 8'h20, 32'h00000100);
        apb(1, 8'h1c, 32'h0);
        rd("ctl1 zero", 8'h10, 32'h000202c0);
        apb(1, 8'h10, 32'h000202c0);
        rd("ctl1 w1c", 8'h10, 32'h00020280);
        chk("port_irq", pirq, 0);
        // Count stands at the limit; only acceptance lets it reach it again
        u_link.accept(4'b0010);
        u_link.retries(4'b0010, 2);
        rd("ctl1 again", 8'h10, 32'h000302c0);
        rd("irq status retry", 8'h40, 32'h00000002);
        apb(1, 8'h40, 32'h00000002);
    endtask : t_retry
    task automatic t_mcast();
        apb(1, 8'h28, 32'hffffffff);
        @(posedge pclk);
        chk("mcast pulse", mc_seen, 4'b0100);
        rd("mcast read", 8'h28, 32'h0);
    endtask : t_mcast
    task automatic t_silence();
        apb(1, 8'h44, 32'h00000010);
        for (int c = 0; c < 4; c += 3) begin
            apb(1, 8'h04, c << 28);
            sil <= 4'b0001;
            @(posedge pclk);
            sil <= 4'b0000;
            n = 0;
            @(negedge pclk);
            while (silent[0] === 1'b1 && n < 40) begin
                n++;
                @(negedge pclk);
            end
            chk("silent cycles", n, c ? c * 5 : 7);
            // Status and line follow one edge after the period ends
            @(negedge pclk);
            chk("irq", irq, 1);
            @(posedge pclk);
            rd("irq status", 8'h40, 32'h00000010);
            apb(1, 8'h40, 32'h00000010);
            chk("irq cleared", irq, 0);
        end
    endtask : t_silence
    task automatic final_report();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset();
        t_retry();
        t_mcast();
        t_silence();
        final_report();
    end
    // Whole run is under two hundred cycles
    initial begin
        #20us;
        fails++;
        final_report();
    end
endmodule : port_retry_error_silence_ctl_tb
